// ### scds_pkg.sv
// Package for the serial control and display select register bank.
// Assumes a byte-wide serial link with frame framing handled by the main module.
`default_nettype none

package scds_pkg;

	// Register addresses on the serial link and the largest read count
	localparam logic [15:0] SCDS_ADDR_DISPLAY_ONE      = 16'h0038;
	localparam logic [15:0] SCDS_ADDR_DISPLAY_END      = 16'h003C;
	localparam logic [15:0] SCDS_ADDR_DISPLAY_SELECT   = 16'h0043;
	localparam logic [15:0] SCDS_ADDR_OPERATION_CMD    = 16'h0044;
	localparam logic [15:0] SCDS_MAX_READ_COUNT        = 16'h0004;

	// Function and exception codes, broadcast station address
	localparam logic [7:0]  SCDS_FC_READ_INPUT         = 8'h04;
	localparam logic [7:0]  SCDS_FC_WRITE_SINGLE       = 8'h06;
	localparam logic [7:0]  SCDS_FC_EXCEPTION          = 8'h80;
	localparam logic [7:0]  SCDS_EXC_BAD_FUNCTION      = 8'h01;
	localparam logic [7:0]  SCDS_EXC_BAD_ADDRESS       = 8'h02;
	localparam logic [7:0]  SCDS_EXC_BAD_VALUE         = 8'h03;
	localparam logic [7:0]  SCDS_BROADCAST_ADDR        = 8'h00;

	// Operation command fields
	localparam int          SCDS_RUN_BIT               = 0;
	localparam int          SCDS_MODE_BIT              = 1;
	localparam int          SCDS_ALARM_RESET_BIT       = 2;
	localparam logic [15:0] SCDS_OPERATION_CMD_MASK    = 16'h0007;

	// Reset values
	localparam logic [15:0] SCDS_DISPLAY_SELECT_RESET  = 16'h0000;
	localparam logic [15:0] SCDS_OPERATION_CMD_RESET   = 16'h0000;

	// Selector field width and codes
	localparam int          SCDS_SEL_WIDTH             = 4;
	localparam logic [3:0]  SCDS_SEL_NONE              = 4'h0;
	localparam logic [3:0]  SCDS_SEL_AMBIENT           = 4'h1;
	localparam logic [3:0]  SCDS_SEL_EXT_TUNE          = 4'h2;
	localparam logic [3:0]  SCDS_SEL_INLET             = 4'h3;
	localparam logic [3:0]  SCDS_SEL_MAINT             = 4'h4;
	localparam logic [3:0]  SCDS_SEL_PRESSURE          = 4'h5;

	// Temperature span, 0.1 degree per count
	localparam logic [15:0] SCDS_TEMP_MIN              = 16'hF334;
	localparam logic [15:0] SCDS_TEMP_MAX              = 16'h0CCC;

	// Frame check, framing character, request length and buffer depth constants
	localparam logic [15:0] SCDS_CRC_INIT              = 16'hFFFF;
	localparam logic [15:0] SCDS_CRC_POLY              = 16'hA001;
	localparam logic [7:0]  SCDS_CHAR_START            = 8'h3A;
	localparam logic [7:0]  SCDS_CHAR_CR               = 8'h0D;
	localparam logic [7:0]  SCDS_CHAR_LF               = 8'h0A;
	localparam logic [3:0]  SCDS_REQ_LEN_RTU           = 4'h8;
	localparam logic [3:0]  SCDS_REQ_LEN_ASCII         = 4'h7;
	localparam int          SCDS_RX_DEPTH              = 8;
	localparam int          SCDS_TX_DEPTH              = 11;

	// Live quantities that the display registers may show
	typedef struct packed {
		logic [15:0] ambient;
		logic [15:0] ext_tune;
		logic [15:0] inlet;
		logic [15:0] maint;
		logic [15:0] pressure;
	} scds_sources_t;

	// Reply sequencer states
	typedef enum logic [2:0] {
		SCDS_S_RX   = 3'b000,
		SCDS_S_HDR  = 3'b001,
		SCDS_S_BODY = 3'b010,
		SCDS_S_CHK  = 3'b011,
		SCDS_S_TRL  = 3'b100
	} scds_state_t;

	// Clamp a signed temperature into the displayable span
	function automatic logic [15:0] scds_clamp_temp(input logic [15:0] t);
		if ($signed(t) < $signed(SCDS_TEMP_MIN))
			return SCDS_TEMP_MIN;
		else if ($signed(t) > $signed(SCDS_TEMP_MAX))
			return SCDS_TEMP_MAX;
		else
			return t;
	endfunction

	// Value shown for one selector code
	function automatic logic [15:0] scds_pick(input logic [3:0] sel, input scds_sources_t s,
			input logic ext_on);
		case (sel)
			SCDS_SEL_AMBIENT:  return scds_clamp_temp(s.ambient);
			SCDS_SEL_EXT_TUNE: return ext_on ? scds_clamp_temp(s.ext_tune) : SCDS_TEMP_MIN;
			SCDS_SEL_INLET:    return scds_clamp_temp(s.inlet);
			SCDS_SEL_MAINT:    return s.maint;
			SCDS_SEL_PRESSURE: return s.pressure;
			default:           return 16'h0000;
		endcase
	endfunction

	// ASCII hex digit to {valid, nibble}
	function automatic logic [4:0] scds_hex_val(input logic [7:0] c);
		if (c >= 8'h30 && c <= 8'h39)
			return {1'b1, 4'(c - 8'h30)};
		else if (c >= 8'h41 && c <= 8'h46)
			return {1'b1, 4'(c - 8'h37)};
		else
			return 5'h00;
	endfunction

	// Nibble to upper-case ASCII hex digit
	function automatic logic [7:0] scds_hex_char(input logic [3:0] n);
		return (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
	endfunction

endpackage

`default_nettype wire

// ### scds_check.sv
// Running frame check: CRC for binary framing, byte sum for ASCII framing.
// Assumes one byte per enable strobe; clear restarts both sums.
`timescale 1ns/1ns
`default_nettype none

module scds_check
(
	// Clock and reset
	input  wire logic        mclk_in,
	input  wire logic        rst_b_in,
	// Byte stream
	input  wire logic        clear_in,
	input  wire logic        en_in,
	input  wire logic [7:0]  data_in,
	// Running sums
	output logic      [15:0] crc_out,
	output logic      [7:0]  sum_out
);

	logic [15:0] crc_reg;
	logic [15:0] crc_next;
	logic [7:0]  sum_reg;

	always_comb
	begin
		crc_next = crc_reg ^ {8'h00, data_in};
		for (int i = 0; i < 8; i++)
		begin
			crc_next = crc_next[0] ? ((crc_next >> 1) ^ scds_pkg::SCDS_CRC_POLY) : (crc_next >> 1);
		end
	end

	always_ff @(posedge mclk_in)
	begin
		if (!rst_b_in || clear_in)
		begin
			crc_reg <= scds_pkg::SCDS_CRC_INIT;
			sum_reg <= 8'h00;
		end
		else if (en_in)
		begin
			crc_reg <= crc_next;
			sum_reg <= sum_reg + data_in;
		end
	end

	assign crc_out = crc_reg;
	assign sum_out = sum_reg;

endmodule // scds_check

`default_nettype wire

// ### scds_regs.sv
// Serial slave register bank: operation command, display select, four displays.
// Assumes a byte link with ready/valid on the reply side and a silence pulse
// ending binary frames; link inputs are synchronous to mclk_in.
`timescale 1ns/1ns
`default_nettype none

module scds_regs
(
	// Clock and reset
	input  wire logic                  mclk_in,
	input  wire logic                  rst_b_in,
	// Link configuration
	input  wire logic [7:0]            slave_addr_in,
	input  wire logic                  ascii_mode_in,
	// Receive byte stream
	input  wire logic [7:0]            rx_data_in,
	input  wire logic                  rx_valid_in,
	input  wire logic                  rx_end_in,
	// Reply byte stream
	output logic      [7:0]            tx_data_out,
	output logic                       tx_valid_out,
	input  wire logic                  tx_ready_in,
	// Local configuration and live values
	input  wire logic                  contact_input_run_option_in,
	input  wire logic                  ext_tune_enable_in,
	input  wire logic                  serial_mode_cancel_in,
	input  wire scds_pkg::scds_sources_t sources_in,
	// Product control and frame error flag
	output logic                       run_cmd_out,
	output logic                       serial_mode_out,
	output logic                       alarm_reset_out,
	output logic                       frame_error_out
);

	scds_pkg::scds_state_t state_reg;
	logic [15:0] display_select_reg;
	logic [15:0] operation_cmd_reg;
	logic [15:0] display_reg [0:3];
	logic [7:0]  rx_buf [0:scds_pkg::SCDS_RX_DEPTH-1];
	logic [7:0]  tx_buf [0:scds_pkg::SCDS_TX_DEPTH-1];
	logic [3:0]  rx_cnt_reg;
	logic        rx_ovf_reg;
	logic        rx_bad_reg;
	logic        rx_phase_reg;
	logic [3:0]  rx_hi_reg;
	logic [3:0]  tx_len_reg;
	logic [3:0]  tx_idx_reg;
	logic        tx_phase_reg;
	logic [7:0]  tx_data_reg;
	logic        tx_valid_reg;
	logic        run_reg;
	logic        serial_mode_reg;
	logic        alarm_reset_reg;
	logic        frame_error_reg;

	// Receive decode
	logic        bin_stb;
	logic [7:0]  bin_byte;
	logic        frame_start;
	logic        frame_end;
	logic        char_bad;
	logic [4:0]  hex_v;
	logic [15:0] rx_crc;
	logic [7:0]  rx_sum;
	logic        frame_ok;
	logic        exec;
	logic [7:0]  req_fc;
	logic [15:0] req_addr;
	logic [15:0] req_val;
	logic        wr_select;
	logic        wr_cmd;
	logic        read_ok;

	// Reply sequencing
	logic        adv;
	logic        tx_feed;
	logic [7:0]  tx_byte;
	logic [15:0] tx_crc;
	logic [7:0]  tx_sum;
	logic [7:0]  lrc;

	always_comb
	begin
		bin_stb     = 1'b0;
		bin_byte    = rx_data_in;
		frame_start = 1'b0;
		frame_end   = 1'b0;
		char_bad    = 1'b0;
		hex_v       = scds_pkg::scds_hex_val(rx_data_in);
		if (state_reg == scds_pkg::SCDS_S_RX)
		begin
			if (!ascii_mode_in)
			begin
				bin_stb   = rx_valid_in;
				frame_end = rx_end_in;
			end
			else if (rx_valid_in)
			begin
				if (rx_data_in == scds_pkg::SCDS_CHAR_START)
					frame_start = 1'b1;
				else if (rx_data_in == scds_pkg::SCDS_CHAR_LF)
					frame_end = 1'b1;
				else if (hex_v[4])
				begin
					bin_stb  = rx_phase_reg;
					bin_byte = {rx_hi_reg, hex_v[3:0]};
				end
				else if (rx_data_in != scds_pkg::SCDS_CHAR_CR)
					char_bad = 1'b1;
			end
		end
	end

	scds_check rx_check
	(
		.mclk_in  (mclk_in),
		.rst_b_in (rst_b_in),
		.clear_in (frame_start || frame_end),
		.en_in    (bin_stb),
		.data_in  (bin_byte),
		.crc_out  (rx_crc),
		.sum_out  (rx_sum)
	);

	// Whole frame including its check field sums to zero when intact
	assign frame_ok = !rx_ovf_reg && !rx_bad_reg && !rx_phase_reg
		&& (ascii_mode_in ? (rx_cnt_reg == scds_pkg::SCDS_REQ_LEN_ASCII && rx_sum == 8'h00)
		: (rx_cnt_reg == scds_pkg::SCDS_REQ_LEN_RTU && rx_crc == 16'h0000));
	assign exec      = frame_end && frame_ok
		&& (rx_buf[0] == slave_addr_in || rx_buf[0] == scds_pkg::SCDS_BROADCAST_ADDR);
	assign req_fc    = rx_buf[1];
	assign req_addr  = {rx_buf[2], rx_buf[3]};
	assign req_val   = {rx_buf[4], rx_buf[5]};
	assign wr_select = exec && req_fc == scds_pkg::SCDS_FC_WRITE_SINGLE
		&& req_addr == scds_pkg::SCDS_ADDR_DISPLAY_SELECT;
	assign wr_cmd    = exec && req_fc == scds_pkg::SCDS_FC_WRITE_SINGLE
		&& req_addr == scds_pkg::SCDS_ADDR_OPERATION_CMD;
	assign read_ok   = req_addr >= scds_pkg::SCDS_ADDR_DISPLAY_ONE
		&& req_val != 16'h0000 && req_val <= scds_pkg::SCDS_MAX_READ_COUNT
		&& (17'(req_addr) + 17'(req_val)) <= 17'(scds_pkg::SCDS_ADDR_DISPLAY_END);

	// Receive buffer
	always_ff @(posedge mclk_in)
	begin
		if (!rst_b_in || frame_start || frame_end)
		begin
			rx_cnt_reg   <= 4'h0;
			rx_ovf_reg   <= 1'b0;
			rx_bad_reg   <= 1'b0;
			rx_phase_reg <= 1'b0;
			rx_hi_reg    <= 4'h0;
		end
		else
		begin
			if (char_bad)
				rx_bad_reg <= 1'b1;
			if (ascii_mode_in && rx_valid_in && hex_v[4] && state_reg == scds_pkg::SCDS_S_RX)
			begin
				rx_phase_reg <= !rx_phase_reg;
				rx_hi_reg    <= hex_v[3:0];
			end
			if (bin_stb)
			begin
				if (rx_cnt_reg == 4'(scds_pkg::SCDS_RX_DEPTH))
					rx_ovf_reg <= 1'b1;
				else
				begin
					rx_buf[rx_cnt_reg[2:0]] <= bin_byte;
					rx_cnt_reg              <= rx_cnt_reg + 4'h1;
				end
			end
		end
	end

	// Writable registers
	always_ff @(posedge mclk_in)
	begin
		if (!rst_b_in)
		begin
			display_select_reg <= scds_pkg::SCDS_DISPLAY_SELECT_RESET;
			operation_cmd_reg  <= scds_pkg::SCDS_OPERATION_CMD_RESET;
		end
		else
		begin
			if (wr_select)
				display_select_reg <= req_val;
			if (wr_cmd)
				operation_cmd_reg <= req_val & scds_pkg::SCDS_OPERATION_CMD_MASK;
		end
	end

	// Operation effects from command writes
	always_ff @(posedge mclk_in)
	begin
		if (!rst_b_in)
		begin
			serial_mode_reg <= 1'b0;
			run_reg         <= 1'b0;
			alarm_reset_reg <= 1'b0;
		end
		else
		begin
			// Entry wins over a simultaneous local cancel
			if (wr_cmd && req_val[scds_pkg::SCDS_MODE_BIT] && !operation_cmd_reg[scds_pkg::SCDS_MODE_BIT])
				serial_mode_reg <= 1'b1;
			else if (serial_mode_cancel_in)
				serial_mode_reg <= 1'b0;
			if (serial_mode_reg && !contact_input_run_option_in)
				run_reg <= operation_cmd_reg[scds_pkg::SCDS_RUN_BIT];
			alarm_reset_reg <= wr_cmd && serial_mode_reg
				&& req_val[scds_pkg::SCDS_ALARM_RESET_BIT]
				&& !operation_cmd_reg[scds_pkg::SCDS_ALARM_RESET_BIT];
		end
	end

	// Displays follow their selectors every cycle
	always_ff @(posedge mclk_in)
	begin
		for (int d = 0; d < 4; d++)
		begin
			if (!rst_b_in)
				display_reg[d] <= 16'h0000;
			else
				display_reg[d] <= scds_pkg::scds_pick(display_select_reg[d*4 +: scds_pkg::SCDS_SEL_WIDTH],
					sources_in, ext_tune_enable_in);
		end
	end

	// Reply construction and sequencing
	assign adv     = !tx_valid_reg || tx_ready_in;
	assign tx_byte = tx_buf[tx_idx_reg];
	assign tx_feed = state_reg == scds_pkg::SCDS_S_BODY && adv && (!ascii_mode_in || tx_phase_reg);
	assign lrc     = 8'h00 - tx_sum;

	scds_check tx_check
	(
		.mclk_in  (mclk_in),
		.rst_b_in (rst_b_in),
		.clear_in (exec),
		.en_in    (tx_feed),
		.data_in  (tx_byte),
		.crc_out  (tx_crc),
		.sum_out  (tx_sum)
	);

	always_ff @(posedge mclk_in)
	begin
		if (!rst_b_in)
		begin
			state_reg    <= scds_pkg::SCDS_S_RX;
			tx_len_reg   <= 4'h0;
			tx_idx_reg   <= 4'h0;
			tx_phase_reg <= 1'b0;
			tx_data_reg  <= 8'h00;
			tx_valid_reg <= 1'b0;
		end
		else
		begin
			if (tx_ready_in)
				tx_valid_reg <= 1'b0;
			case (state_reg)
				scds_pkg::SCDS_S_RX:
				begin
					if (exec && rx_buf[0] != scds_pkg::SCDS_BROADCAST_ADDR)
					begin
						tx_buf[0]    <= slave_addr_in;
						tx_buf[1]    <= req_fc;
						tx_idx_reg   <= 4'h0;
						tx_phase_reg <= 1'b0;
						state_reg    <= ascii_mode_in ? scds_pkg::SCDS_S_HDR : scds_pkg::SCDS_S_BODY;
						if (wr_select || wr_cmd)
						begin
							for (int i = 2; i < 6; i++)
								tx_buf[i] <= rx_buf[i];
							tx_len_reg <= 4'h6;
						end
						else if (req_fc == scds_pkg::SCDS_FC_READ_INPUT && read_ok)
						begin
							tx_buf[2] <= {req_val[6:0], 1'b0};
							for (int i = 0; i < 4; i++)
							begin
								tx_buf[3 + 2*i] <= display_reg[2'(req_addr[1:0] + 2'(i))][15:8];
								tx_buf[4 + 2*i] <= display_reg[2'(req_addr[1:0] + 2'(i))][7:0];
							end
							tx_len_reg <= 4'(3 + 2*req_val[2:0]);
						end
						else
						begin
							tx_buf[1] <= req_fc | scds_pkg::SCDS_FC_EXCEPTION;
							if (req_fc == scds_pkg::SCDS_FC_READ_INPUT)
								tx_buf[2] <= (req_val == 16'h0000 || req_val > scds_pkg::SCDS_MAX_READ_COUNT)
									? scds_pkg::SCDS_EXC_BAD_VALUE : scds_pkg::SCDS_EXC_BAD_ADDRESS;
							else if (req_fc == scds_pkg::SCDS_FC_WRITE_SINGLE)
								tx_buf[2] <= scds_pkg::SCDS_EXC_BAD_ADDRESS;
							else
								tx_buf[2] <= scds_pkg::SCDS_EXC_BAD_FUNCTION;
							tx_len_reg <= 4'h3;
						end
					end
				end
				scds_pkg::SCDS_S_HDR:
				begin
					if (adv)
					begin
						tx_data_reg  <= scds_pkg::SCDS_CHAR_START;
						tx_valid_reg <= 1'b1;
						state_reg    <= scds_pkg::SCDS_S_BODY;
					end
				end
				scds_pkg::SCDS_S_BODY:
				begin
					if (adv)
					begin
						tx_valid_reg <= 1'b1;
						if (ascii_mode_in)
						begin
							tx_data_reg  <= scds_pkg::scds_hex_char(tx_phase_reg ? tx_byte[3:0] : tx_byte[7:4]);
							tx_phase_reg <= !tx_phase_reg;
						end
						else
							tx_data_reg <= tx_byte;
						if (!ascii_mode_in || tx_phase_reg)
						begin
							tx_idx_reg <= tx_idx_reg + 4'h1;
							if (tx_idx_reg == tx_len_reg - 4'h1)
								state_reg <= scds_pkg::SCDS_S_CHK;
						end
					end
				end
				scds_pkg::SCDS_S_CHK:
				begin
					if (adv)
					begin
						tx_valid_reg <= 1'b1;
						tx_phase_reg <= !tx_phase_reg;
						if (ascii_mode_in)
							tx_data_reg <= scds_pkg::scds_hex_char(tx_phase_reg ? lrc[3:0] : lrc[7:4]);
						else
							tx_data_reg <= tx_phase_reg ? tx_crc[15:8] : tx_crc[7:0];
						if (tx_phase_reg)
							state_reg <= ascii_mode_in ? scds_pkg::SCDS_S_TRL : scds_pkg::SCDS_S_RX;
					end
				end
				scds_pkg::SCDS_S_TRL:
				begin
					if (adv)
					begin
						tx_valid_reg <= 1'b1;
						tx_phase_reg <= !tx_phase_reg;
						tx_data_reg  <= tx_phase_reg ? scds_pkg::SCDS_CHAR_LF : scds_pkg::SCDS_CHAR_CR;
						if (tx_phase_reg)
							state_reg <= scds_pkg::SCDS_S_RX;
					end
				end
				default:
					state_reg <= scds_pkg::SCDS_S_RX;
			endcase
		end
	end

	// Frame error flag, one cycle per rejected frame
	always_ff @(posedge mclk_in)
	begin
		if (!rst_b_in)
			frame_error_reg <= 1'b0;
		else
			frame_error_reg <= frame_end && !frame_ok && rx_cnt_reg != 4'h0;
	end

	assign tx_data_out     = tx_data_reg;
	assign tx_valid_out    = tx_valid_reg;
	assign run_cmd_out     = run_reg;
	assign serial_mode_out = serial_mode_reg;
	assign alarm_reset_out = alarm_reset_reg;
	assign frame_error_out = frame_error_reg;

endmodule // scds_regs

`default_nettype wire

// ### scds_regs_checker.sv
// Checker for the reply stream, product control and frame error outputs of scds_regs.
// Assumes one clock domain, bound to every instance of scds_regs.
`timescale 1ns/1ns
`default_nettype none
module scds_regs_checker
(
	// Clock, reset and configuration
	input wire logic       mclk_in,
	input wire logic       rst_b_in,
	input wire logic       ascii_mode_in,
	input wire logic       contact_input_run_option_in,
	input wire logic       serial_mode_cancel_in,
	// Reply stream
	input wire logic [7:0] tx_data_out,
	input wire logic       tx_valid_out,
	input wire logic       tx_ready_in,
	// Control outputs
	input wire logic       run_cmd_out,
	input wire logic       serial_mode_out,
	input wire logic       alarm_reset_out,
	input wire logic       frame_error_out
);
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_b_in);
	a_alarm_one_cycle: assert property (alarm_reset_out |=> !alarm_reset_out)
		else $error("alarm reset pulse longer than one cycle");
	a_alarm_needs_serial: assert property (alarm_reset_out |-> serial_mode_out)
		else $error("alarm reset outside serial mode");
	a_mode_stays_on: assert property (serial_mode_out && !serial_mode_cancel_in |=> serial_mode_out)
		else $error("serial mode left without cancel");
	a_run_held: assert property (!serial_mode_out || contact_input_run_option_in |=> $stable(run_cmd_out))
		else $error("run command changed while gated");
	a_reply_holds: assert property (tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out))
		else $error("reply byte dropped before acceptance");
	a_error_one_cycle: assert property (frame_error_out |=> !frame_error_out)
		else $error("frame error pulse longer than one cycle");
	a_error_silent: assert property (frame_error_out |=> !tx_valid_out [*4])
		else $error("reply sent for dropped frame");
	a_ascii_chars: assert property (tx_valid_out && ascii_mode_in |->
		tx_data_out inside {8'h3A, 8'h0D, 8'h0A, [8'h30:8'h39], [8'h41:8'h46]})
		else $error("illegal character in text reply");
	c_alarm: cover property (alarm_reset_out);
	c_error: cover property (frame_error_out);
	c_stall: cover property (tx_valid_out && !tx_ready_in);
	c_ascii: cover property (tx_valid_out && ascii_mode_in);
endmodule // scds_regs_checker
bind scds_regs scds_regs_checker scds_regs_checker_inst (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
	.ascii_mode_in(ascii_mode_in), .contact_input_run_option_in(contact_input_run_option_in),
	.serial_mode_cancel_in(serial_mode_cancel_in), .tx_data_out(tx_data_out), .tx_valid_out(tx_valid_out),
	.tx_ready_in(tx_ready_in), .run_cmd_out(run_cmd_out), .serial_mode_out(serial_mode_out),
	.alarm_reset_out(alarm_reset_out), .frame_error_out(frame_error_out));
`default_nettype wire

// ### scds_host.sv
// Host model: sends request frames and collects reply bytes.
// Assumes binary frames close with a one-cycle end pulse; drives at falling edges.
`timescale 1ns/1ns
`default_nettype none
module scds_host
(
	// Clock
	input  wire logic       mclk_in,
	// Request stream
	output logic      [7:0] rx_data_out,
	output logic            rx_valid_out,
	output logic            rx_end_out,
	// Reply stream
	input  wire logic [7:0] tx_data_in,
	input  wire logic       tx_valid_in,
	output logic            tx_ready_out
);
	logic [7:0] rs[$];
	logic       slow = 1'b0;
	initial
	begin
		rx_data_out = 8'h00;
		rx_valid_out = 1'b0;
		rx_end_out = 1'b0;
		tx_ready_out = 1'b1;
	end
	task automatic send(input logic [7:0] q[$]);
		foreach (q[i])
		begin
			@(negedge mclk_in);
			rx_data_out = q[i];
			rx_valid_out = 1'b1;
		end
		@(negedge mclk_in);
		rx_valid_out = 1'b0;
		rx_data_out = ~rx_data_out;
		rx_end_out = 1'b1;
		@(negedge mclk_in);
		rx_end_out = 1'b0;
	endtask
	// Stalling sink for replies
	always @(negedge mclk_in)
		tx_ready_out <= slow ? ~tx_ready_out : 1'b1;
	always @(posedge mclk_in)
		if (tx_valid_in && tx_ready_out)
			rs.push_back(tx_data_in);
endmodule // scds_host
`default_nettype wire

// ### serial_control_and_display_select_tb.sv
// Testbench: host model sends frames, a bench model predicts every binary reply.
// Assumes scds_regs at station 01, binary framing except one text frame.
`timescale 1ns/1ns
`default_nettype none
module serial_control_and_display_select_tb;
	logic                    mclk_in = 1'b0;
	logic                    rst_b_in = 1'b0;
	logic                    ascii = 1'b0;
	logic                    opt = 1'b0;
	logic                    ext_on = 1'b0;
	scds_pkg::scds_sources_t src = '0;
	logic [7:0]              rx_data, tx_data;
	logic                    rx_valid, rx_end, tx_valid, tx_ready, run, serial, alarm, ferr;
	logic [31:0]             seed = 32'h281F0BD3;
	int                      errors = 0, n_checks = 0, cycles = 0, n_alarm = 0, n_ferr = 0;
	int                      sel_m = 0, op_m = 0, serial_m = 0, run_m = 0, alarm_m = 0, ferr_m = 0;
	logic [7:0]              q[$];
	string                   msg = ":010600430001B5";
	logic [16:0]             ops[10] = '{17'h00004, 17'h00001, 17'h00003, 17'h00000, 17'h10001,
		17'h00001, 17'h00005, 17'h00005, 17'h0FFF9, 17'h00004};

	always #5 mclk_in = ~mclk_in;

	scds_regs scds_regs_inst (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .slave_addr_in(8'h01),
		.ascii_mode_in(ascii), .rx_data_in(rx_data), .rx_valid_in(rx_valid), .rx_end_in(rx_end),
		.tx_data_out(tx_data), .tx_valid_out(tx_valid), .tx_ready_in(tx_ready),
		.contact_input_run_option_in(opt), .ext_tune_enable_in(ext_on), .serial_mode_cancel_in(1'b0),
		.sources_in(src), .run_cmd_out(run), .serial_mode_out(serial), .alarm_reset_out(alarm),
		.frame_error_out(ferr));
	scds_host scds_host_inst (.mclk_in(mclk_in), .rx_data_out(rx_data), .rx_valid_out(rx_valid),
		.rx_end_out(rx_end), .tx_data_in(tx_data), .tx_valid_in(tx_valid), .tx_ready_out(tx_ready));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [15:0] crc16(input logic [7:0] b[$]);
		logic [15:0] c;
		c = 16'hFFFF;
		foreach (b[i])
		begin
			c ^= {8'h00, b[i]};
			repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
		end
		return c;
	endfunction
	function automatic logic [15:0] temp(input logic [15:0] t);
		if ($signed(t) < $signed(16'hF334)) return 16'hF334;
		if ($signed(t) > $signed(16'h0CCC)) return 16'h0CCC;
		return t;
	endfunction
	function automatic logic [15:0] disp(input int idx);
		case ((sel_m >> (4 * idx)) & 15)
			1: return temp(src.ambient);
			2: return ext_on ? temp(src.ext_tune) : 16'hF334;
			3: return temp(src.inlet);
			4: return src.maint;
			5: return src.pressure;
			default: return 16'h0000;
		endcase
	endfunction
	task automatic model(input logic [7:0] b[$], output logic [7:0] r[$]);
		int a, v;
		logic [15:0] w;
		a = {b[2], b[3]};
		v = {b[4], b[5]};
		r = b;
		if (b[0] > 8'h01) r = {};
		else if (b[1] == 8'h06 && a == 16'h0043) sel_m = v;
		else if (b[1] == 8'h06 && a == 16'h0044)
		begin
			if (v[2] && !op_m[2] && serial_m) alarm_m++;
			if (v[1] && !op_m[1]) serial_m = 1;
			op_m = v & 7;
		end
		else if (b[1] == 8'h06) r = '{b[0], 8'h86, 8'h02};
		else if (b[1] != 8'h04) r = '{b[0], b[1] | 8'h80, 8'h01};
		else if (v < 1 || v > 4) r = '{b[0], 8'h84, 8'h03};
		else if (a < 16'h0038 || a + v > 16'h003C) r = '{b[0], 8'h84, 8'h02};
		else
		begin
			r = '{b[0], b[1], 8'(2 * v)};
			for (int i = 0; i < v; i++)
			begin
				w = disp(a - 16'h0038 + i);
				r = {r, w[15:8], w[7:0]};
			end
		end
		w = crc16(r);
		if (b[0] == 8'h00) r = {};
		if (r.size() > 0) r = {r, w[7:0], w[15:8]};
	endtask
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic xact(input logic [7:0] b[$], input int kind);
		logic [7:0] r[$];
		logic [15:0] c;
		scds_host_inst.rs = {};
		if (kind == 2) r = b;
		else if (kind == 1) ferr_m++;
		else model(b, r);
		c = crc16(b);
		if (kind < 2) b = {b, c[7:0], c[15:8] ^ 8'(kind)};
		scds_host_inst.send(b);
		for (int i = 0; i < 300 && scds_host_inst.rs.size() < r.size(); i++) @(negedge mclk_in);
		repeat (12) @(negedge mclk_in);
		chk("reply length", 16'(r.size()), 16'(scds_host_inst.rs.size()));
		foreach (r[i]) if (i < scds_host_inst.rs.size()) chk("reply byte", 16'(r[i]), 16'(scds_host_inst.rs[i]));
		if (serial_m && !opt) run_m = op_m & 1;
		chk("serial mode", 16'(serial_m), 16'(serial));
		chk("run command", 16'(run_m), 16'(run));
		chk("alarm resets", 16'(alarm_m), 16'(n_alarm));
		chk("frame errors", 16'(ferr_m), 16'(n_ferr));
	endtask
	task automatic finish_test();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	always @(posedge mclk_in)
	begin
		cycles++;
		if (alarm === 1'b1) n_alarm++;
		if (ferr === 1'b1) n_ferr++;
		if (cycles == 20000)
		begin
			errors++;
			finish_test();
		end
	end

	initial
	begin
		logic [7:0] a, n;
		repeat (5) @(negedge mclk_in);
		rst_b_in = 1'b1;
		chk("idle reply", 16'h0000, 16'(tx_valid));
		xact('{8'h01, 8'h06, 8'h00, 8'h43, 8'h00, 8'h01}, 0);
		chk("check low", 16'h00B9, 16'(scds_host_inst.rs[6]));
		chk("check high", 16'h00DE, 16'(scds_host_inst.rs[7]));
		for (int k = 0; k < 12; k++)
		begin
			n = 8'(k / 3 * 4);
			if (k % 3 == 0) xact('{8'h01, 8'h06, 8'h00, 8'h43, 8'((n + 3) * 16 + n + 2), 8'((n + 1) * 16 + n)}, 0);
			src = {rnd(), rnd(), 16'(rnd())};
			ext_on = 1'(rnd());
			scds_host_inst.slow = 1'(rnd());
			a = 8'(rnd() % 4);
			xact('{8'h01, 8'h04, 8'h00, 8'h38 + a, 8'h00, 8'(1 + rnd() % (4 - a))}, 0);
		end
		xact('{8'h01, 8'h04, 8'h00, 8'h38, 8'h00, 8'h00}, 0);
		xact('{8'h01, 8'h04, 8'h00, 8'h50, 8'h00, 8'h01}, 0);
		xact('{8'h01, 8'h04, 8'hFF, 8'hFD, 8'h00, 8'h04}, 0);
		xact('{8'h01, 8'h03, 8'h00, 8'h38, 8'h00, 8'h01}, 0);
		xact('{8'h01, 8'h06, 8'h00, 8'h45, 8'h00, 8'h01}, 0);
		xact('{8'h01, 8'h06, 8'h00, 8'h43, 8'h12, 8'h34}, 1);
		xact('{8'h02, 8'h06, 8'h00, 8'h43, 8'h12, 8'h34}, 0);
		xact('{8'h00, 8'h06, 8'h00, 8'h43, 8'h00, 8'h05}, 0);
		xact('{8'h01, 8'h04, 8'h00, 8'h38, 8'h00, 8'h01}, 0);
		foreach (ops[i])
		begin
			opt = ops[i][16];
			xact('{8'h01, 8'h06, 8'h00, 8'h44, ops[i][15:8], ops[i][7:0]}, 0);
		end
		ascii = 1'b1;
		sel_m = 1;
		foreach (msg[i]) q.push_back(msg[i]);
		xact({q, 8'h0D, 8'h0A}, 2);
		finish_test();
	end
endmodule // serial_control_and_display_select_tb
`default_nettype wire
